// >>> core/drive_fault_trip_manager.sv
// Function
// - Any fault records history, forces output off
// - Internal faults trip while stopped too
// - Stop/reset key press clears latched trip
// - Clear value erases history, keeps settings
// - Trip shows its error code automatically
// - Over-current coded by motion phase
// - Overload trips; low-speed overload separate code
// - Chopper rate above duty limit trips
// - DC bus over-voltage trips
// - Memory fault trips with memory code
// - DC bus under-voltage trips
// - Current detection error trips
// - External and safe-stop inputs trip
// - Run at power-up with guard trips
// - Ground fault tested at power-up
// - Input over-voltage checked after long stop
// - Module over-temperature trips
// - Processor link or processor fault trips
// - Main supply not established trips
// - Driver safety path error trips
// - Thermistor over-temperature trips
// - Missing brake confirmation in time trips
// - Reset ignored ten seconds after trip
// - Memory, ground, driver trips need power cycle
`default_nettype none
module drive_fault_trip_manager #(
  parameter int CYC_PER_MS_P = trip_pkg::CYC_PER_MS,
  parameter int MS_PER_S_P = trip_pkg::MS_PER_S
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire trip_pkg::pins_t pins,
  output logic power_out_en,
  output logic brake_release,
  output logic run_permit,
  output logic tripped,
  output logic [7:0] display_code
);
  import trip_pkg::*;

  pins_t f;
  logic key_d_reg;
  logic term_d_reg;
  logic rst_req;
  logic ms_tick;
  logic s_tick;
  state_t state_reg;
  state_t state_next;
  logic [7:0] code_reg;
  logic [7:0] new_code;
  logic cap;
  logic [4:0] pu_cnt_reg;
  logic [6:0] stop_s_reg;
  logic [3:0] lock_s_reg;
  logic lock_done;
  logic [15:0] bwait_cnt_reg;
  logic brake_to;
  logic [6:0] win_cnt_reg;
  logic [7:0] on_cnt_reg;
  logic duty_over_reg;
  logic [1:0] ctrl_reg;
  logic [7:0] duty_reg;
  logic [15:0] bwait_reg;
  logic [7:0] hist [HIST_DEPTH];
  logic [HIST_AW-1:0] hist_ptr_reg;
  logic [15:0] hist_count_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic ap_valid;
  logic hist_clear;
  logic [31:0] rdata_next;
  logic [7:0] hoff;

  // Trips that only a power cycle clears
  function automatic logic power_only(input logic [7:0] c);
    power_only = (c == CODE_MEM) || (c == CODE_GND) || (c == CODE_DRIVER);
  endfunction

  // Fault priority encoder; hardware faults come first
  function automatic logic [7:0] fault_code(input pins_t p, input logic pu, input logic unattended_start_guard,
                                            input logic inov_armed, input logic bto,
                                            input logic dover);
    fault_code = CODE_NONE;
    if (p.driver)
      fault_code = CODE_DRIVER;
    else if (p.mem_err)
      fault_code = CODE_MEM;
    else if (pu && p.gnd)
      fault_code = CODE_GND;
    else if (p.cpu_err)
      fault_code = CODE_CPU;
    else if (p.cpu_comm)
      fault_code = CODE_CPU_COMM;
    else if (p.main_circ)
      fault_code = CODE_MAIN_CIRC;
    else if (p.cur_det)
      fault_code = CODE_CUR_DET;
    else if (p.safe_stop)
      fault_code = CODE_SAFE_STOP;
    else if (p.external_trip_input)
      fault_code = CODE_EXT;
    else if (pu && unattended_start_guard && p.run_cmd)
      fault_code = CODE_USP;
    else if (p.oc)
    begin
      // Motion phase picks the code; both ramps at once counts as other
      if (!p.run_cmd || (p.accel && p.decel))
        fault_code = CODE_OC_OTHER;
      else if (p.accel)
        fault_code = CODE_OC_ACCEL;
      else if (p.decel)
        fault_code = CODE_OC_DECEL;
      else
        fault_code = CODE_OC_CONST;
    end
    else if (p.bus_uv)
      fault_code = CODE_BUS_UV;
    else if (p.bus_ov)
      fault_code = CODE_BUS_OV;
    else if (inov_armed && p.in_ov)
      fault_code = CODE_IN_OV;
    else if (p.mod_therm)
      fault_code = CODE_MOD_THERM;
    else if (p.thermistor)
      fault_code = CODE_THERMISTOR;
    else if (dover)
      fault_code = CODE_CHOPPER;
    else if (p.overload && p.low_speed)
      fault_code = CODE_LOW_SPEED_OL;
    else if (p.overload)
      fault_code = CODE_OVERLOAD;
    else if (bto)
      fault_code = CODE_BRAKE;
  endfunction

  // Every pin is asynchronous, so all go through the synchroniser
  pin_sync #(.W($bits(pins_t))) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(pins),
    .q(f)
  );

  // Millisecond and second enables from one clock
  tick_divider #(.DIV(CYC_PER_MS_P)) u_ms (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(1'b1),
    .tick(ms_tick)
  );

  tick_divider #(.DIV(MS_PER_S_P)) u_s (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(ms_tick),
    .tick(s_tick)
  );

  // Reset request on rising edge of key or terminal
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key_d_reg <= 1'b0;
      term_d_reg <= 1'b0;
    end
    else
    begin
      key_d_reg <= f.stop_reset_key;
      term_d_reg <= f.reset_input_terminal;
    end
  end
  assign rst_req = (f.stop_reset_key && !key_d_reg) || (f.reset_input_terminal && !term_d_reg);

  // Power-up test window for ground fault and start guard
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pu_cnt_reg <= '0;
    else if (pu_cnt_reg != GND_TEST_CYC)
      pu_cnt_reg <= pu_cnt_reg + 1'b1;
  end

  // Stopped-time counter arms the input over-voltage check
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stop_s_reg <= '0;
    else if (f.run_cmd)
      stop_s_reg <= '0;
    else if (s_tick && stop_s_reg != IN_OV_STOP_S)
      stop_s_reg <= stop_s_reg + 1'b1;
  end

  // Lockout after a trip; restarts on every capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lock_s_reg <= '0;
    else if (cap)
      lock_s_reg <= '0;
    else if (s_tick && lock_s_reg != RESET_LOCK_S)
      lock_s_reg <= lock_s_reg + 1'b1;
  end
  assign lock_done = (lock_s_reg == RESET_LOCK_S);

  // Brake confirmation wait in milliseconds; clears once confirmed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bwait_cnt_reg <= '0;
    else if (!brake_release || f.brake_confirm)
      bwait_cnt_reg <= '0;
    else if (ms_tick && !brake_to)
      bwait_cnt_reg <= bwait_cnt_reg + 1'b1;
  end
  assign brake_to = brake_release && !f.brake_confirm && (bwait_cnt_reg >= bwait_reg);

  // Chopper duty sampled each ms over a 100 ms window, as a percentage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      win_cnt_reg <= '0;
      on_cnt_reg <= '0;
      duty_over_reg <= 1'b0;
    end
    else if (ms_tick)
    begin
      if (win_cnt_reg == DUTY_WINDOW_MS - 7'h01)
      begin
        win_cnt_reg <= '0;
        on_cnt_reg <= '0;
        duty_over_reg <= (on_cnt_reg > duty_reg);
      end
      else
      begin
        win_cnt_reg <= win_cnt_reg + 1'b1;
        on_cnt_reg <= on_cnt_reg + {7'h00, f.braking_resistor_chopper};
      end
    end
  end

  // Next state; a latched trip ignores fault removal
  always_comb
  begin
    new_code = fault_code(f, state_reg == ST_POWERUP, ctrl_reg[CTRL_USP_BIT],
                          stop_s_reg == IN_OV_STOP_S, brake_to, duty_over_reg);
    state_next = state_reg;
    cap = 1'b0;
    case (state_reg)
      ST_POWERUP, ST_READY:
      begin
        if (new_code != CODE_NONE)
        begin
          state_next = ST_TRIPPED;
          cap = 1'b1;
        end
        else if (state_reg == ST_POWERUP && pu_cnt_reg == GND_TEST_CYC)
          state_next = ST_READY;
      end
      default:
      begin
        if (rst_req && lock_done && !power_only(code_reg))
          state_next = ST_READY;
      end
    endcase
  end

  // State, code and user-side outputs, all from flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_POWERUP;
      code_reg <= CODE_NONE;
      tripped <= 1'b0;
      display_code <= CODE_NONE;
      power_out_en <= 1'b0;
      run_permit <= 1'b0;
      brake_release <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (cap)
        code_reg <= new_code;
      tripped <= (state_next == ST_TRIPPED);
      display_code <= cap ? new_code : (state_next == ST_TRIPPED) ? code_reg : CODE_NONE;
      power_out_en <= (state_next == ST_READY) && f.run_cmd;
      run_permit <= (state_next == ST_READY);
      brake_release <= (state_next == ST_READY) && f.run_cmd && ctrl_reg[CTRL_BRAKE_BIT];
    end
  end

  // History ring; a capture in the clear cycle lands in slot 0
  assign hist_clear = wr_pend_reg && wr_addr_reg == ADDR_INIT && hwdata[7:0] == HIST_CLEAR_VAL;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hist_ptr_reg <= '0;
      hist_count_reg <= '0;
      for (int i = 0; i < HIST_DEPTH; i++)
        hist[i] <= CODE_NONE;
    end
    else
    begin
      if (hist_clear)
      begin
        for (int i = 0; i < HIST_DEPTH; i++)
          hist[i] <= CODE_NONE;
        hist_ptr_reg <= cap ? HIST_AW'(1) : '0;
        hist_count_reg <= cap ? 16'h0001 : 16'h0000;
        if (cap)
          hist[0] <= new_code;
      end
      else if (cap)
      begin
        hist[hist_ptr_reg] <= new_code;
        hist_ptr_reg <= hist_ptr_reg + 1'b1;
        if (hist_count_reg != 16'hFFFF)
          hist_count_reg <= hist_count_reg + 1'b1;
      end
    end
  end

  // Bus slave: zero wait states, always OKAY
  assign ap_valid = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= ap_valid && hwrite;
      if (ap_valid)
        wr_addr_reg <= haddr[7:0];
    end
  end

  // Settings written in the data phase; history clear leaves them alone
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= CTRL_RST;
      duty_reg <= DUTY_RST;
      bwait_reg <= BWAIT_RST;
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == ADDR_CTRL)
        ctrl_reg <= hwdata[1:0];
      else if (wr_addr_reg == ADDR_DUTY)
        duty_reg <= hwdata[7:0];
      else if (wr_addr_reg == ADDR_BWAIT)
        bwait_reg <= hwdata[15:0];
    end
  end

  // Read data prepared from the address phase so it stands in the data phase
  always_comb
  begin
    hoff = haddr[7:0] - ADDR_HIST0;
    rdata_next = 32'h0000_0000;
    if (haddr[7:0] == ADDR_CTRL)
      rdata_next = {30'h0, ctrl_reg};
    else if (haddr[7:0] == ADDR_DUTY)
      rdata_next = {24'h0, duty_reg};
    else if (haddr[7:0] == ADDR_BWAIT)
      rdata_next = {16'h0, bwait_reg};
    else if (haddr[7:0] == ADDR_STATUS)
      rdata_next = {20'h0, run_permit, power_only(code_reg), !lock_done, tripped, code_reg};
    else if (haddr[7:0] == ADDR_COUNT)
      rdata_next = {16'h0, hist_count_reg};
    else if (haddr[7:0] >= ADDR_HIST0 && haddr[7:0] < ADDR_HIST_END)
      rdata_next = {24'h0, hist[hoff[HIST_AW+1:2]]};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (ap_valid && !hwrite)
      hrdata <= rdata_next;
  end

  trip_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cap |=> tripped && !power_out_en)
    else $error("trip did not force output off");
  stop_trip_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_READY && !f.run_cmd && f.cpu_err |=> tripped)
    else $error("stopped fault not tripped");
  code_show_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cap |=> display_code == $past(new_code))
    else $error("display code wrong");
  oc_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cap && new_code == CODE_OC_DECEL |-> f.oc && f.decel && !f.accel && f.run_cmd)
    else $error("overcurrent phase code wrong");
  lock_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_TRIPPED && !lock_done |=> state_reg == ST_TRIPPED)
    else $error("reset taken during lockout");
  power_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_TRIPPED && power_only(code_reg) |=> state_reg == ST_TRIPPED)
    else $error("power-cycle trip cleared");
  run_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tripped |-> !run_permit && !power_out_en)
    else $error("run allowed while tripped");
  hist_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    hist_clear && !cap |=> hist_count_reg == 16'h0000 && $stable(ctrl_reg))
    else $error("history clear wrong");
  brake_to_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_READY && brake_to && !f.driver |=> ##[0:1] tripped)
    else $error("brake timeout did not trip");
  clear_ok_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_TRIPPED && rst_req && lock_done && !power_only(code_reg)
    |=> state_reg == ST_READY)
    else $error("accepted reset ignored");
endmodule
`default_nettype wire

// >>> core/trip_pkg.sv
`default_nettype none
package trip_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  // Supervision times, in seconds, milliseconds or clock cycles as counted
  localparam logic [3:0] RESET_LOCK_S = 4'hA;
  localparam logic [6:0] IN_OV_STOP_S = 7'h64;
  localparam logic [6:0] DUTY_WINDOW_MS = 7'h64;
  localparam logic [4:0] GND_TEST_CYC = 5'h10;
  // Trip history
  localparam int HIST_DEPTH = 4;
  localparam int HIST_AW = 2;
  localparam logic [7:0] HIST_CLEAR_VAL = 8'h00;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DUTY = 8'h04;
  localparam logic [7:0] ADDR_BWAIT = 8'h08;
  localparam logic [7:0] ADDR_INIT = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_HIST0 = 8'h20;
  localparam logic [7:0] ADDR_HIST_END = 8'h30;
  // Control fields and reset values
  localparam int CTRL_USP_BIT = 0;
  localparam int CTRL_BRAKE_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [7:0] DUTY_RST = 8'h0A;
  localparam logic [15:0] BWAIT_RST = 16'h0064;
  // Display error codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_OC_CONST = 8'h01;
  localparam logic [7:0] CODE_OC_DECEL = 8'h02;
  localparam logic [7:0] CODE_OC_ACCEL = 8'h03;
  localparam logic [7:0] CODE_OC_OTHER = 8'h04;
  localparam logic [7:0] CODE_OVERLOAD = 8'h05;
  localparam logic [7:0] CODE_CHOPPER = 8'h06;
  localparam logic [7:0] CODE_BUS_OV = 8'h07;
  localparam logic [7:0] CODE_MEM = 8'h08;
  localparam logic [7:0] CODE_BUS_UV = 8'h09;
  localparam logic [7:0] CODE_CUR_DET = 8'h0A;
  localparam logic [7:0] CODE_CPU = 8'h0B;
  localparam logic [7:0] CODE_EXT = 8'h0C;
  localparam logic [7:0] CODE_USP = 8'h0D;
  localparam logic [7:0] CODE_GND = 8'h0E;
  localparam logic [7:0] CODE_IN_OV = 8'h0F;
  localparam logic [7:0] CODE_MOD_THERM = 8'h15;
  localparam logic [7:0] CODE_CPU_COMM = 8'h16;
  localparam logic [7:0] CODE_MAIN_CIRC = 8'h19;
  localparam logic [7:0] CODE_DRIVER = 8'h1E;
  localparam logic [7:0] CODE_THERMISTOR = 8'h23;
  localparam logic [7:0] CODE_BRAKE = 8'h24;
  localparam logic [7:0] CODE_SAFE_STOP = 8'h25;
  localparam logic [7:0] CODE_LOW_SPEED_OL = 8'h26;

  // Fault, status and operator pins, all asynchronous to hclk
  typedef struct packed {
    logic oc;
    logic accel;
    logic decel;
    logic overload;
    logic low_speed;
    logic bus_ov;
    logic mem_err;
    logic bus_uv;
    logic cur_det;
    logic cpu_err;
    logic cpu_comm;
    logic external_trip_input;
    logic safe_stop;
    logic gnd;
    logic in_ov;
    logic mod_therm;
    logic main_circ;
    logic driver;
    logic thermistor;
    logic brake_confirm;
    logic braking_resistor_chopper;
    logic run_cmd;
    logic stop_reset_key;
    logic reset_input_terminal;
  } pins_t;

  typedef enum logic [1:0] {ST_POWERUP, ST_READY, ST_TRIPPED} state_t;
endpackage
`default_nettype wire

// >>> core/pin_sync.sv
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> core/tick_divider.sv
`default_nettype none
module tick_divider #(
  parameter int DIV = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic en,
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt_reg;

  // Counts enable pulses, emits one-cycle tick every DIV of them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (en)
      begin
        if (cnt_reg == CW'(DIV - 1))
        begin
          cnt_reg <= '0;
          tick <= 1'b1;
        end
        else
        begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/keypad_stage_model.sv
`default_nettype none
module keypad_stage_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic press_req,
  input wire logic confirm_en,
  input wire logic [4:0] confirm_lag,
  input wire logic brake_release,
  output logic stop_reset_key,
  output logic brake_confirm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] key_cnt_reg;
  logic [4:0] lag_reg;

  // Key held eight cycles so the pin synchroniser sees exactly one rising edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      key_cnt_reg <= 4'h0;
    else if (press_req)
      key_cnt_reg <= 4'h8;
    else if (key_cnt_reg != 4'h0)
      key_cnt_reg <= key_cnt_reg - 4'h1;
  end
  assign stop_reset_key = (key_cnt_reg != 4'h0);

  // Brake contact closes after a mechanical lag; the bench sets the lag once, to 20 cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lag_reg <= 5'h00;
    else if (!brake_release || !confirm_en)
      lag_reg <= 5'h00;
    else if (lag_reg != 5'h1F)
      lag_reg <= lag_reg + 5'h01;
  end
  // Confirmation drops as soon as release goes away, never lingers
  assign brake_confirm = confirm_en && brake_release && (lag_reg >= confirm_lag);
endmodule
`default_nettype wire

// >>> sim/drive_fault_trip_manager_test.sv
`default_nettype none
module drive_fault_trip_manager_test;
  import trip_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 40000;
  localparam logic [23:0] RUN_M = 24'h000004;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [23:0] drv;
  pins_t pins;
  logic power_out_en;
  logic brake_release;
  logic run_permit;
  logic tripped;
  logic [7:0] display_code;
  logic press_req;
  logic confirm_en;
  logic [4:0] confirm_lag;
  logic key_w;
  logic confirm_w;
  logic use_rs;
  logic [31:0] rd;
  int err_count = 0;
  int check_count = 0;
  int trips = 0;
  int cycles = 0;

  // Keypad and brake contact come from the partner, all other pins from the bench
  assign pins = drv | {19'h0, confirm_w, 2'h0, key_w, 1'h0};

  // Short ms and s ticks keep lockout and stop timers inside the run budget
  drive_fault_trip_manager #(.CYC_PER_MS_P(10), .MS_PER_S_P(5)) u_drive_fault_trip_manager (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
    .power_out_en(power_out_en), .brake_release(brake_release), .run_permit(run_permit),
    .tripped(tripped), .display_code(display_code));

  keypad_stage_model u_keypad_stage_model (
    .hclk(hclk), .hresetn(hresetn), .press_req(press_req), .confirm_en(confirm_en),
    .confirm_lag(confirm_lag), .brake_release(brake_release),
    .stop_reset_key(key_w), .brake_confirm(confirm_w));

  // 200 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic complete_run();
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard: a stuck wait ends the run as a failure
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One single-word transfer; each phase held until hready is sampled high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Alternates keypad and reset terminal; the keypad takes each early refused press, the terminal each late one
  task automatic press();
    @(posedge hclk);
    if (use_rs)
      drv[0] <= 1'b1;
    else
      press_req <= 1'b1;
    @(posedge hclk);
    press_req <= 1'b0;
    repeat (8) @(posedge hclk);
    drv[0] <= 1'b0;
    use_rs <= ~use_rs;
  endtask

  task automatic power_cycle(input logic [23:0] hold);
    drv <= hold;
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (25) @(posedge hclk);
    drv <= 24'h0;
  endtask

  task automatic hit(input logic [7:0] code, input logic sticky);
    check(tripped, 1'b1);
    check(power_out_en, 1'b0);
    check(run_permit, 1'b0);
    check(display_code, code);
    rd_chk(ADDR_STATUS, {20'h0, 1'b0, sticky, 2'h3, code});
  endtask

  // Fault already gone: trip must hold, early reset is refused, late one clears unless sticky
  task automatic clear_trip(input logic sticky, input int hold);
    repeat (30) @(posedge hclk);
    check(tripped, 1'b1);
    press();
    repeat (10) @(posedge hclk);
    check(tripped, 1'b1);
    repeat (hold) @(posedge hclk);
    press();
    repeat (10) @(posedge hclk);
    check(tripped, sticky);
    check(run_permit, !sticky);
  endtask

  task automatic fire(input logic [23:0] m, input logic [7:0] code, input logic run,
                      input logic sticky, input int lim);
    int n;
    drv <= run ? RUN_M : 24'h0;
    repeat (6) @(posedge hclk);
    check(power_out_en, run);
    drv <= drv | m;
    for (n = 0; n < lim && tripped !== 1'b1; n++)
      @(posedge hclk);
    @(posedge hclk);
    drv <= 24'h0;
    hit(code, sticky);
    trips++;
    rd_chk(ADDR_COUNT, trips);
    rd_chk(ADDR_HIST0 + 8'(((trips - 1) % 4) * 4), {24'h0, code});
    // The duty flag stands until the next whole window is judged, so wait past it
    clear_trip(sticky, (code == CODE_CHOPPER) ? 1200 : 600);
  endtask

  task automatic boot(input logic [23:0] m, input logic [7:0] code, input logic sticky);
    power_cycle(m);
    hit(code, sticky);
    clear_trip(sticky, 600);
  endtask

  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    drv = 24'h0;
    press_req = 1'b0;
    confirm_en = 1'b0;
    confirm_lag = 5'h14;
    use_rs = 1'b0;
    power_cycle(24'h0);
    check(run_permit, 1'b1);
    rd_chk(ADDR_CTRL, 32'h1);
    rd_chk(ADDR_DUTY, 32'h0A);
    rd_chk(ADDR_BWAIT, 32'h64);
    bus(1'b1, ADDR_STATUS, 32'hFF);
    rd_chk(ADDR_STATUS, 32'hA00);
    rd_chk(8'h40, 32'h0);
    fire(24'h040000, CODE_BUS_OV, 1'b0, 1'b0, 6);
    fire(24'h010000, CODE_BUS_UV, 1'b0, 1'b0, 6);
    fire(24'h008000, CODE_CUR_DET, 1'b0, 1'b0, 6);
    fire(24'h004000, CODE_CPU, 1'b0, 1'b0, 6);
    fire(24'h002000, CODE_CPU_COMM, 1'b0, 1'b0, 6);
    fire(24'h001000, CODE_EXT, 1'b1, 1'b0, 6);
    fire(24'h000800, CODE_SAFE_STOP, 1'b0, 1'b0, 6);
    fire(24'h000100, CODE_MOD_THERM, 1'b0, 1'b0, 6);
    fire(24'h000080, CODE_MAIN_CIRC, 1'b0, 1'b0, 6);
    fire(24'h000020, CODE_THERMISTOR, 1'b0, 1'b0, 6);
    fire(24'h100000, CODE_OVERLOAD, 1'b1, 1'b0, 6);
    fire(24'h180000, CODE_LOW_SPEED_OL, 1'b1, 1'b0, 6);
    fire(24'h800000, CODE_OC_CONST, 1'b1, 1'b0, 6);
    fire(24'hA00000, CODE_OC_DECEL, 1'b1, 1'b0, 6);
    fire(24'hC00000, CODE_OC_ACCEL, 1'b1, 1'b0, 6);
    fire(24'h800000, CODE_OC_OTHER, 1'b0, 1'b0, 6);
    // Only the clear value wipes history; settings survive it
    bus(1'b1, ADDR_DUTY, 32'h37);
    bus(1'b1, ADDR_INIT, 32'h05);
    rd_chk(ADDR_COUNT, trips);
    bus(1'b1, ADDR_INIT, 32'h00);
    trips = 0;
    rd_chk(ADDR_COUNT, 32'h0);
    rd_chk(ADDR_HIST0, 32'h0);
    rd_chk(ADDR_DUTY, 32'h37);
    rd_chk(ADDR_CTRL, 32'h1);
    bus(1'b1, ADDR_DUTY, 32'h0A);
    fire(24'h000008, CODE_CHOPPER, 1'b0, 1'b0, 2500);
    // Input over-voltage must wait out the stop interval; a short run restarts it
    drv <= RUN_M;
    repeat (4) @(posedge hclk);
    drv <= 24'h000200;
    repeat (200) @(posedge hclk);
    check(tripped, 1'b0);
    fire(24'h000200, CODE_IN_OV, 1'b0, 1'b0, 6000);
    // Slow but timely confirmation keeps running; missing one trips
    bus(1'b1, ADDR_CTRL, 32'h3);
    confirm_en <= 1'b1;
    drv <= RUN_M;
    repeat (1500) @(posedge hclk);
    check(brake_release, 1'b1);
    check(tripped, 1'b0);
    confirm_en <= 1'b0;
    fire(24'h0, CODE_BRAKE, 1'b1, 1'b0, 1500);
    bus(1'b1, ADDR_CTRL, 32'h1);
    // Trips that only a power cycle clears, then a start-guard trip that a reset clears
    fire(24'h020000, CODE_MEM, 1'b0, 1'b1, 6);
    power_cycle(24'h0);
    check(tripped, 1'b0);
    bus(1'b1, ADDR_INIT, 32'h00);
    trips = 0;
    fire(24'h000040, CODE_DRIVER, 1'b0, 1'b1, 6);
    boot(24'h000400, CODE_GND, 1'b1);
    boot(RUN_M, CODE_USP, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
